//--- core/artimer.sv
// Reload timer: counter, prescaler, edge logic, event flags and APB register file
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module artimer (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // APB slave
  input  wire artimer_pkg::apb_req_t apb_req,
  output var  artimer_pkg::apb_rsp_t apb_rsp,
  // Timer pin
  input  wire logic                 timer_input_pin,
  // Outputs
  output logic                      pwm_out,
  output logic                      irq
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] mode_q;
  logic [7:0] cfg_q;
  logic [7:0] reload_q;
  logic [7:0] compare_q;
  logic [7:0] timer_counter_q;
  logic [6:0] timer_prescaler_q;
  logic [1:0] div3_q;
  logic [2:0] flags_q;
  logic [2:0] irq_en_q;
  logic       pin_meta_q;
  logic       pin_sync_q;
  logic       pin_prev_q;
  logic       match_prev_q;
  logic       pwm_q;
  logic       pwm_out_q;
  logic       irq_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0] idx;
  logic       aligned;
  logic       access;
  logic       mapped;
  logic [7:0] wdata;

  assign idx     = apb_req.paddr[9:2];
  assign aligned = (apb_req.paddr[1:0] == 2'b00)
                 && (apb_req.paddr[11:10] == 2'b00);
  assign access  = apb_req.psel && apb_req.penable && pready_q;
  assign wdata   = apb_req.pwdata[7:0];

  // Known register indices
  always_comb begin
    case (idx)
      artimer_pkg::IDX_MODE,
      artimer_pkg::IDX_FLAGS,
      artimer_pkg::IDX_CFG,
      artimer_pkg::IDX_RELOAD,
      artimer_pkg::IDX_COMPARE,
      artimer_pkg::IDX_COUNTER,
      artimer_pkg::IDX_IRQ_STAT,
      artimer_pkg::IDX_IRQ_CLR,
      artimer_pkg::IDX_IRQ_EN: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // Write strobes, one per register except the interrupt status, which writes leave alone
  wire wr         = access && apb_req.pwrite && mapped;
  wire wr_mode    = wr && (idx == artimer_pkg::IDX_MODE);
  wire wr_flags   = wr && (idx == artimer_pkg::IDX_FLAGS);
  wire wr_cfg     = wr && (idx == artimer_pkg::IDX_CFG);
  wire wr_reload  = wr && (idx == artimer_pkg::IDX_RELOAD);
  wire wr_compare = wr && (idx == artimer_pkg::IDX_COMPARE);
  wire wr_counter = wr && (idx == artimer_pkg::IDX_COUNTER);
  wire wr_irq_clr = wr && (idx == artimer_pkg::IDX_IRQ_CLR);
  wire wr_irq_en  = wr && (idx == artimer_pkg::IDX_IRQ_EN);

  // ****************************************
  // Field views
  // ****************************************
  artimer_pkg::mode_select_t         mode_select;
  artimer_pkg::clock_source_select_t clock_source_select;
  logic [2:0] divider_select;
  logic       edge_detect_enable;
  logic       edge_polarity;
  logic       timer_enable;

  assign mode_select         = artimer_pkg::mode_select_t'(mode_q[1:0]);
  assign timer_enable        = mode_q[artimer_pkg::MODE_TEN];
  assign divider_select      = cfg_q[artimer_pkg::CFG_DIV_LSB +: 3];
  assign edge_detect_enable  = cfg_q[artimer_pkg::CFG_EDGE_EN];
  assign edge_polarity       = cfg_q[artimer_pkg::CFG_POL];
  assign clock_source_select =
    artimer_pkg::clock_source_select_t'(cfg_q[artimer_pkg::CFG_SRC_LSB +: 2]);

  // ****************************************
  // Pin synchroniser
  // ****************************************
  // Two stages, then one more for edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= timer_input_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  wire pin_rise = pin_sync_q && !pin_prev_q;
  wire pin_fall = !pin_sync_q && pin_prev_q;
  // Edge only counts when enabled, polarity picks the direction
  wire edge_hit = edge_detect_enable
                && (edge_polarity ? pin_fall : pin_rise);

  // ****************************************
  // Clock source multiplexer
  // ****************************************
  // Divide-by-three runs freely from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div3_q <= 2'h0;
    end else if (div3_q == artimer_pkg::DIV3_LAST) begin
      div3_q <= 2'h0;
    end else begin
      div3_q <= div3_q + 2'h1;
    end
  end

  logic src_tick;

  always_comb begin
    case (clock_source_select)
      artimer_pkg::SRC_INTERNAL: src_tick = 1'b1;
      artimer_pkg::SRC_DIV3:     src_tick = (div3_q == artimer_pkg::DIV3_LAST);
      artimer_pkg::SRC_PIN:      src_tick = pin_rise;
      default:                   src_tick = 1'b0;
    endcase
  end

  // ****************************************
  // Prescaler tap
  // ****************************************
  // Terminal when the low select bits are all ones
  wire [6:0] tap_mask   = 7'((8'h01 << divider_select) - 8'h01);
  wire       presc_term = ((timer_prescaler_q & tap_mask) == tap_mask);
  wire       step       = timer_enable && src_tick && presc_term;

  // ****************************************
  // Counter load sources
  // ****************************************
  wire overflow  = step && (timer_counter_q == artimer_pkg::COUNT_MAX);
  wire capture   = edge_hit && ((mode_select == artimer_pkg::MODE_CAPTURE)
                 || (mode_select == artimer_pkg::MODE_CAPTURE_RST));
  wire cap_reset = edge_hit && (mode_select == artimer_pkg::MODE_CAPTURE_RST);
  wire edge_load = edge_hit && (mode_select == artimer_pkg::MODE_LOAD_ON_EDGE);
  wire tcld      = wr_mode && wdata[artimer_pkg::MODE_LOAD];
  wire load_any  = overflow || cap_reset || edge_load || tcld
                 || wr_counter || wr_reload;

  // Prescaler counts source ticks; select writes leave it alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_prescaler_q <= artimer_pkg::PRESC_RST;
    end else if (load_any) begin
      timer_prescaler_q <= artimer_pkg::PRESC_RST;
    end else if (timer_enable && src_tick) begin
      timer_prescaler_q <= timer_prescaler_q + 7'h01;
    end
  end

  // Live counter keeps its value over reset
  always_ff @(posedge clk) begin
    if (wr_counter) begin
      timer_counter_q <= wdata;
    end else if (wr_reload) begin
      timer_counter_q <= wdata;
    end else if (tcld || edge_load) begin
      timer_counter_q <= reload_q;
    end else if (cap_reset) begin
      timer_counter_q <= 8'h00;
    end else if (overflow) begin
      timer_counter_q <= reload_q;
    end else if (step) begin
      timer_counter_q <= timer_counter_q + 8'h01;
    end
  end

  // ****************************************
  // Reload and compare registers
  // ****************************************
  // Reload takes software data or a capture of the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= artimer_pkg::DATA_RST;
    end else if (wr_reload) begin
      reload_q <= wdata;
    end else if (capture) begin
      reload_q <= timer_counter_q;
    end
  end

  // Software settings: compare, mode, clock and edge, interrupt enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      compare_q <= artimer_pkg::DATA_RST;
      mode_q    <= artimer_pkg::MODE_RST;
      cfg_q     <= artimer_pkg::CFG_RST;
      irq_en_q  <= artimer_pkg::FLAGS_RST;
    end else begin
      if (wr_compare) begin
        compare_q <= wdata;
      end
      if (wr_mode) begin
        mode_q <= {1'b0, wdata[6:0]}; // Load bit is a strobe
      end
      if (wr_cfg) begin
        cfg_q <= wdata; // Reserved bit stored as written
      end
      if (wr_irq_en) begin
        irq_en_q <= wdata[2:0];
      end
    end
  end

  // ****************************************
  // Event flags
  // ****************************************
  logic       match_now;
  logic [2:0] set_ev;
  logic [2:0] keep;

  // Rising of equality is the match event
  assign match_now = (timer_counter_q == compare_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_prev_q <= 1'b0;
    end else begin
      match_prev_q <= match_now;
    end
  end

  // A stopped timer raises no match, so a count never loaded stays quiet
  assign set_ev = {edge_hit, match_now && !match_prev_q && timer_enable, overflow};

  // Zeros clear through the flags register, ones through the clear register
  always_comb begin
    keep = 3'b111;
    if (wr_flags) begin
      keep = keep & wdata[2:0];
    end
    if (wr_irq_clr) begin
      keep = keep & ~wdata[2:0];
    end
  end

  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= artimer_pkg::FLAGS_RST;
    end else begin
      flags_q <= (flags_q & keep) | set_ev;
    end
  end

  // ****************************************
  // Interrupt and PWM outputs
  // ****************************************
  wire [2:0] mode_en = mode_q[artimer_pkg::MODE_OVIE +: 3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & mode_en & irq_en_q);
    end
  end

  // Overflow sets the wave, a match resets it; pin copy gated by its enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q     <= 1'b0;
      pwm_out_q <= 1'b0;
    end else begin
      pwm_out_q <= pwm_q && mode_q[artimer_pkg::MODE_PWMOE];
      if (overflow) begin
        pwm_q <= 1'b1;
      end else if (set_ev[artimer_pkg::FLAG_MATCH]) begin
        pwm_q <= 1'b0;
      end
    end
  end

  assign irq     = irq_q;
  assign pwm_out = pwm_out_q;

  // ****************************************
  // APB answer
  // ****************************************
  logic [7:0] rd_byte;

  always_comb begin
    case (idx)
      artimer_pkg::IDX_MODE:     rd_byte = mode_q;
      artimer_pkg::IDX_FLAGS:    rd_byte = {5'h00, flags_q};
      artimer_pkg::IDX_CFG:      rd_byte = cfg_q;
      artimer_pkg::IDX_RELOAD:   rd_byte = reload_q;
      artimer_pkg::IDX_COMPARE:  rd_byte = compare_q;
      artimer_pkg::IDX_COUNTER:  rd_byte = timer_counter_q;
      artimer_pkg::IDX_IRQ_STAT: rd_byte = {5'h00, flags_q};
      artimer_pkg::IDX_IRQ_EN:   rd_byte = {5'h00, irq_en_q};
      default:                   rd_byte = 8'h00;
    endcase
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= apb_req.psel && apb_req.penable && !pready_q;
      pslverr_q <= apb_req.psel && apb_req.penable && !pready_q && !mapped;
      if (apb_req.psel && apb_req.penable && !pready_q
          && !apb_req.pwrite && mapped) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.pslverr = pslverr_q;
  assign apb_rsp.prdata  = prdata_q;

endmodule

`default_nettype wire

//--- core/artimer_pkg.sv
// Package: register map, field layout, reset values and bus types of the reload timer
package artimer_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_MODE     = 8'hd5;
  localparam logic [7:0] IDX_FLAGS    = 8'hd6;
  localparam logic [7:0] IDX_CFG      = 8'hd7;
  localparam logic [7:0] IDX_RELOAD   = 8'hd9;
  localparam logic [7:0] IDX_COMPARE  = 8'hda;
  localparam logic [7:0] IDX_COUNTER  = 8'hdb;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hdc;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'hdd;
  localparam logic [7:0] IDX_IRQ_EN   = 8'hde;
  localparam int         ADDR_W       = 12;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FLAG_EDGE  = 2;
  localparam int FLAG_MATCH = 1;
  localparam int FLAG_ROLL  = 0;
  localparam int MODE_LOAD  = 7;
  localparam int MODE_TEN   = 6;
  localparam int MODE_PWMOE = 5;
  localparam int MODE_EIE   = 4;
  localparam int MODE_CPIE  = 3;
  localparam int MODE_OVIE  = 2;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_RSVD    = 4;
  localparam int CFG_POL     = 3;
  localparam int CFG_EDGE_EN = 2;
  localparam int CFG_SRC_LSB = 0;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [2:0] FLAGS_RST   = 3'h0;
  localparam logic [6:0] PRESC_RST   = 7'h00;
  localparam logic [1:0] DIV3_LAST   = 2'h2;
  localparam logic [7:0] COUNT_MAX   = 8'hff;

  // ****************************************
  // Enumerations
  // ****************************************
  typedef enum logic [1:0] {
    MODE_AUTO_RELOAD  = 2'b00,
    MODE_CAPTURE      = 2'b01,
    MODE_CAPTURE_RST  = 2'b10,
    MODE_LOAD_ON_EDGE = 2'b11
  } mode_select_t;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_DIV3     = 2'b01,
    SRC_PIN      = 2'b10,
    SRC_NONE     = 2'b11
  } clock_source_select_t;

  // ****************************************
  // APB carriers
  // ****************************************
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

//--- verif/artimer_bench.sv
// Testbench: registers, counting, flags, edges, capture modes and interrupt
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

module artimer_bench;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  x;
    logic        e;
  } row_t;
  logic                  clk;
  logic                  rst_n;
  artimer_pkg::apb_req_t req;
  artimer_pkg::apb_rsp_t rsp;
  logic                  pin;
  logic                  pwm;
  logic                  irq;
  logic                  run;
  logic [3:0]            half;
  int                    miscompares;
  int                    tests_run;
  int                    cycles;
  logic [11:0]           ra [6] = '{12'h354, 12'h358, 12'h35c, 12'h364, 12'h368, 12'h378};
  logic [7:0]            exp_rl [4] = '{8'h99, 8'h42, 8'h42, 8'h99};
  logic [7:0]            exp_ct [4] = '{8'h42, 8'h42, 8'h00, 8'h99};
  row_t                  rows [10] = '{
    '{12'h35c, 8'hed, 8'hed, 1'b0}, '{12'h368, 8'ha5, 8'ha5, 1'b0},
    '{12'h364, 8'h3c, 8'h3c, 1'b0}, '{12'h36c, 8'h77, 8'h77, 1'b0},
    '{12'h358, 8'hff, 8'h00, 1'b0}, '{12'h354, 8'h9c, 8'h1c, 1'b0},
    '{12'h378, 8'h07, 8'h07, 1'b0}, '{12'h374, 8'h07, 8'h00, 1'b0},
    '{12'h360, 8'h5a, 8'h00, 1'b1}, '{12'h359, 8'h5a, 8'h00, 1'b1}};

  // ****************************************
  // Instances, clock and timeout
  // ****************************************
  artimer artimer_inst (
    .clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .timer_input_pin(pin), .pwm_out(pwm), .irq(irq)
  );
  pin_source pin_source_inst (.clk(clk), .rst_n(rst_n), .run(run), .half(half), .pin(pin));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    // Ends once ready is seen; only the bench timeout ends a hang here
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       e;
    apb(a, 1'b1, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] q);
    logic e;
    apb(a, 1'b0, 8'h00, q, e);
  endtask

  task automatic toggle(input logic [3:0] h);
    half <= h;
    run  <= 1'b1;
    repeat (h) @(posedge clk);
    run  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic count(input logic [7:0] cfg, input int cyc, input logic [7:0] lo, hi);
    logic [7:0] q;
    wr(12'h35c, cfg);
    wr(12'h36c, 8'h00);
    wr(12'h354, 8'h40);
    repeat (cyc) @(posedge clk);
    wr(12'h354, 8'h00);
    rd(12'h36c, q);
    `CHK("count", 1'b1, q >= lo && q <= hi)
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] q;
    logic       e;
    logic       pol;
    int         hi;
    req = '0;
    run = 1'b0;
    half = 4'h2;
    rst_n = 1'b0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ra[i]) begin
      rd(ra[i], q);
      `CHK("reset value", 8'h00, q)
    end
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d, q, e);
      apb(rows[i].a, 1'b0, 8'h00, q, e);
      `CHK("readback", rows[i].x, q)
      `CHK("error", rows[i].e, e)
    end
    $display("test register map done");
    wr(12'h36c, 8'h5a);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(12'h36c, q);
    `CHK("counter after reset", 8'h5a, q)
    $display("test reset keeps counter done");
    for (int n = 0; n < 8; n++) count(8'(n << 5), 40 << n, 8'h27, 8'h2e);
    count(8'h01, 120, 8'h27, 8'h2e);
    count(8'h03, 60, 8'h00, 8'h00);
    run <= 1'b1;
    half <= 4'h3;
    count(8'h02, 240, 8'h27, 8'h2e);
    run <= 1'b0;
    $display("test dividers and sources done");
    wr(12'h364, 8'hfc);
    wr(12'h368, 8'hfe);
    wr(12'h35c, 8'h00);
    wr(12'h358, 8'h00);
    wr(12'h354, 8'h60);
    repeat (5) @(posedge clk);
    hi = 0;
    // Period fc to ff: wave high three counts of four
    repeat (16) begin
      hi += pwm;
      @(posedge clk);
    end
    `CHK("pwm high cycles", 12, hi)
    wr(12'h354, 8'h00);
    rd(12'h36c, q);
    `CHK("reloaded count", 1'b1, q >= 8'hfc)
    rd(12'h358, q);
    `CHK("flags after rollover", 8'h03, q)
    wr(12'h358, 8'h06);
    rd(12'h358, q);
    `CHK("rollover cleared alone", 8'h02, q)
    wr(12'h358, 8'h05);
    rd(12'h358, q);
    `CHK("match cleared", 8'h00, q)
    $display("test rollover and match done");
    wr(12'h354, 8'h10);
    wr(12'h378, 8'h04);
    for (int k = 0; k < 4; k++) begin
      pol = (k == 2) ? ~pin : pin;
      wr(12'h35c, {4'h0, pol, (k != 0), 2'b11});
      wr(12'h358, 8'h00);
      toggle(k[0] ? 4'h2 : 4'h6);
      repeat (8) @(posedge clk);
      rd(12'h358, q);
      `CHK("edge flag", k[0], q[2])
    end
    `CHK("irq raised", 1'b1, irq)
    rd(12'h370, q);
    `CHK("interrupt status", 8'h04, q)
    wr(12'h378, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(12'h378, 8'h04);
    repeat (2) @(posedge clk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(12'h374, 8'h04);
    wr(12'h358, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test edges and interrupt done");
    wr(12'h35c, 8'h07);
    for (int m = 0; m < 4; m++) begin
      wr(12'h354, 8'h00);
      wr(12'h364, 8'h99);
      wr(12'h36c, 8'h42);
      wr(12'h354, 8'(m));
      toggle(4'h6);
      toggle(4'h2);
      repeat (8) @(posedge clk);
      rd(12'h364, q);
      `CHK("reload after edge", exp_rl[m], q)
      rd(12'h36c, q);
      `CHK("counter after edge", exp_ct[m], q)
    end
    $display("test modes done");
    end_sim();
  end
endmodule

`default_nettype wire

//--- verif/artimer_chk.sv
// Checker: bus timing, register map and interrupt masking of the reload timer
`timescale 1ns/10ps
`default_nettype none

module artimer_chk (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Bus
  input wire artimer_pkg::apb_req_t apb_req,
  input wire artimer_pkg::apb_rsp_t apb_rsp,
  // Pins
  input wire logic                  timer_input_pin,
  input wire logic                  pwm_out,
  input wire logic                  irq
);
  logic       wr_ok;
  logic [7:0] mode_q;
  logic [7:0] cfg_q;
  logic [7:0] ien_q;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Shadow registers
  // ****************************************
  assign wr_ok = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;

  // Follow committed writes of mode, config and irq enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 8'h00;
      cfg_q  <= 8'h00;
      ien_q  <= 8'h00;
    end else if (wr_ok) begin
      if (apb_req.paddr == 12'h354) mode_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == 12'h35c) cfg_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == 12'h378) ien_q <= apb_req.pwdata[7:0];
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_answer;
    apb_req.psel && !apb_req.penable |=> !apb_rsp.pready ##1 apb_rsp.pready;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  property p_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");

  property p_misalign;
    apb_rsp.pready && apb_req.paddr[1:0] != 2'h0 |-> apb_rsp.pslverr;
  endproperty
  a_misalign: assert property (p_misalign) else $error("misaligned accepted");

  property p_hole;
    apb_rsp.pready && apb_req.paddr == 12'h360 |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("hole accepted");

  property p_flags_hi;
    apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h358
      |-> apb_rsp.prdata[7:3] == 5'h00 && !apb_rsp.pslverr;
  endproperty
  a_flags_hi: assert property (p_flags_hi) else $error("flag upper bits set");

  property p_mapped;
    apb_rsp.pready && apb_req.paddr == 12'h35c |-> !apb_rsp.pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("config refused");

  property p_mask;
    irq |-> $past(mode_q[4:2] & ien_q[2:0]) != 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");

  property p_drop;
    wr_ok && apb_req.paddr == 12'h378 && apb_req.pwdata[2:0] == 3'h0 |-> ##2 !irq;
  endproperty
  a_drop: assert property (p_drop) else $error("irq stays after mask");

  property p_edge;
    $rose(timer_input_pin) && cfg_q[3:2] == 2'b01 && mode_q[4] && ien_q[2] |-> ##[1:8] irq;
  endproperty
  a_edge: assert property (p_edge) else $error("edge gave no irq");

  c_write: cover property (wr_ok);
  c_err: cover property (apb_rsp.pready && apb_rsp.pslverr);
  c_irq: cover property ($rose(irq));
endmodule

bind artimer artimer_chk artimer_chk_inst (
  .clk(clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .timer_input_pin(timer_input_pin), .pwm_out(pwm_out), .irq(irq)
);

`default_nettype wire

//--- verif/pin_source.sv
// Partner model: drives the timer input pin, promptly or slowly, still when idle
`timescale 1ns/10ps
`default_nettype none

module pin_source (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control from the bench
  input  wire logic       run,
  input  wire logic [3:0] half,
  // Pin
  output logic            pin
);
  logic [3:0] cnt_q;

  // Toggle every half cycles while run is high, hold the level otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      pin   <= 1'b0;
    end else if (run) begin
      cnt_q <= (cnt_q == half - 4'h1) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == half - 4'h1) begin
        pin <= ~pin;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end
endmodule

`default_nettype wire
